// ---- bench/i2c_host.sv ----
`timescale 1ns/1ps
module i2c_host (
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic drv = 1'b1;
  // pull-up: released line reads high
  assign sda = drv & ~sda_oe;
  initial scl = 1'b1;
  task q;
    repeat (3) @(negedge sys_clk);
  endtask
  task start;
    drv = 1'b1;
    q;
    scl = 1'b1;
    q;
    drv = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask
  task stop;
    drv = 1'b0;
    q;
    scl = 1'b1;
    q;
    drv = 1'b1;
    q;
  endtask
  // data moves only while scl is low, so no false start or stop
  task xfer(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      drv = w[i];
      q;
      scl = 1'b1;
      q;
      r[i] = sda;
      q;
      scl = 1'b0;
      q;
    end
  endtask
  task wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [8:0] r0, r1, r2;
    start;
    xfer({dev, 1'b1}, r0);
    xfer({a, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    stop;
    ok = ~(r0[0] | r1[0] | r2[0]);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r;
    start;
    xfer({8'h60, 1'b1}, r);
    xfer({a, 1'b1}, r);
    start;
    xfer({8'h61, 1'b1}, r);
    xfer(9'h1FF, r);
    stop;
    d = r[8:1];
  endtask
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import pmu_pkg::*;
  localparam logic [7:0][15:0] CAUSE = {16'h0100, 16'h0200, 16'h0002, 16'h0008,
                                        16'h0010, 16'h0020, 16'h0080, 16'h0080};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl_in, sda_in, sda_out, sda_oe, supplies_off, simultaneous_off_select, reset_out, ok;
  logic wake_pin = 1'b0;
  logic [3:0] ev = '0;
  logic [7:0] c = '0;
  logic [7:0] v;
  logic [6:0] reg_fault = '0;
  logic [6:0] reg_pg_in = '0;
  logic [6:0] regulator_force_off;
  logic [5:0] reg_oc_flag = '0;
  logic [2:0] conv_pg_in = '0;
  wire [19:0] f;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  i2c_host h (.sys_clk, .sda_oe, .scl(scl_in), .sda(sda_in));
  pmu_state_control_registers #(.TICK_CYCLES(10)) uut (
    .sys_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .wake_pin,
    .alarm_event(ev[3]), .key_long_event(ev[2]), .key_short_event(ev[1]), .bus_insert_event(ev[0]),
    .path_oc_event(c[0]), .bus_switch_oc_event(c[1]), .pwrok_fault_event(c[2]), .overtemp_event(c[3]),
    .low_power_event(c[4]), .key_reset_event(c[5]), .reset_in_low_event(c[6]), .path_ov_event(c[7]),
    .reg_fault, .reg_oc_flag, .conv_pg_in, .reg_pg_in, .supplies_off, .simultaneous_off_select,
    .reset_out, .regulator_force_off, .bus_switch_overcurrent_threshold(f[19:17]),
    .bus_switch_overvoltage_threshold(f[16]), .overtemp_protect_enable(f[15]), .overtemp_threshold(f[14:13]),
    .bus_overcurrent_irq_threshold(f[12:11]), .bus_undervoltage_threshold(f[10:9]),
    .battery_low_threshold(f[8:7]), .bus_switch_wake_threshold(f[6]), .bus_switch_shutdown_speed(f[5:4]),
    .bus_pulldown_enable(f[3]), .switching_frequency_select(f[2:0])
  );
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // whole run is near 80k cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    h.rd(a, v);
    chk(n, e, v);
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    h.wr(8'h60, a, d, ok);
  endtask
  task step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task do_reset;
    rst = 1'b1;
    step(10);
    rst = 1'b0;
    step(2);
  endtask
  task wake;
    ev = 4'h2;
    step(1);
    ev = 4'h0;
    step(2);
  endtask
  task t_reset;
    for (int i = 0; i < N_RW; i++) rchk("reset value", RW_ADDR[i], RW_RST[i]);
    chk("fields", 20'h8CCF2, f);
    chk("sda drive level", 1'b0, sda_out);
    $display("test reset done");
  endtask
  task t_rw;
    // bank 0x00 is skipped: its low bit would start a sleep
    for (int p = 0; p < 2; p++) begin
      for (int i = 1; i < N_RW; i++) begin
        wreg(RW_ADDR[i], p ? 8'h00 : 8'hFF);
        rchk("masked", RW_ADDR[i], (RW_RST[i] & ~RW_WMASK[i]) | (p ? 8'h00 : RW_WMASK[i]));
      end
      chk("fields", p ? 20'h0 : 20'hFFFFF, f);
    end
    wreg(8'h30, 8'h5A);
    rchk("unmapped", 8'h30, 8'h00);
    h.wr(8'h62, 8'h01, 8'h00, ok);
    chk("foreign ack", 1'b0, ok);
    $display("test rw done");
  endtask
  task t_status;
    reg_pg_in = 7'h55;
    reg_oc_flag = 6'h2A;
    conv_pg_in = 3'h5;
    rchk("reg good", A_REG_PG, 8'hAA);
    rchk("oc flags", A_OCFLAG, 8'hA8);
    rchk("conv off", A_CONV_PG, 8'h00);
    wreg(8'h20, 8'h17);
    rchk("conv on", A_CONV_PG, 8'h0A);
    $display("test status done");
  endtask
  task t_sleep(input logic dly);
    wreg(8'h04, dly ? 8'hC4 : 8'h04);
    wreg(8'h00, dly ? 8'h19 : 8'h1B);
    if (dly) begin
      step(40);
      chk("early off", 1'b0, supplies_off);
      step(30);
    end else step(2);
    chk("asleep", {1'b1, dly, ~dly}, {supplies_off, reset_out, simultaneous_off_select});
    rchk("sleep bit", 8'h00, dly ? 8'h18 : 8'h1A);
    rchk("off cause", A_POFF_A, 8'h01);
    wreg(A_POFF_A, 8'h00);
    rchk("kept", A_POFF_A, 8'h01);
    wake;
    chk("awake", 2'b01, {supplies_off, reset_out});
    rchk("on cause", A_PON_A, 8'h04);
    wreg(A_POFF_A, 8'h01);
    rchk("cleared", A_POFF_A, 8'h00);
    $display("test sleep done");
  endtask
  task t_causes;
    for (int i = 0; i < 8; i++) begin
      c = 8'h01 << i;
      step(1);
      c = 8'h00;
      step(2);
      chk("fault off", 2'b10, {supplies_off, reset_out});
      rchk("cause", A_POFF_A, CAUSE[i][7:0]);
      h.rd(A_POFF_B, v);
      chk("cause b", CAUSE[i][15:8], v);
      wreg(A_POFF_A, 8'hFF);
      wreg(A_POFF_B, 8'hFF);
      wake;
    end
    // protection off: these events must neither trip nor record
    wreg(8'h08, 8'h02);
    wreg(8'h0A, 8'hBC);
    c = 8'h0A;
    step(3);
    c = 8'h00;
    chk("gated faults", 1'b0, supplies_off);
    wreg(8'h1B, 8'h04);
    reg_fault = 7'h02;
    step(3);
    chk("masked fault", 8'h02, {supplies_off, regulator_force_off});
    reg_fault = 7'h04;
    step(3);
    reg_fault = 7'h00;
    chk("unmasked", 1'b1, supplies_off);
    rchk("reg cause", A_POFF_A, 8'h40);
    wreg(A_POFF_A, 8'hFF);
    wake;
    $display("test causes done");
  endtask
  task t_wake;
    for (int p = 0; p < 4; p++) begin
      wake_pin = p[0];
      wreg(8'h01, {2'b00, p[1:0], 4'h1});
      wreg(8'h00, 8'h59);
      step(20);
      chk("idle pin", 1'b1, supplies_off);
      wake_pin = ~p[0];
      step(3);
      chk("pin wake", 1'b0, supplies_off);
      rchk("pin cause", A_PON_A, 8'h10);
    end
    wreg(A_POFF_A, 8'hFF);
    $display("test wake done");
  endtask
  task t_wdog;
    wreg(8'h1A, 8'h08);
    step(4000);
    wreg(8'h1A, 8'h0C);
    step(4500);
    chk("wd kicked", 1'b0, supplies_off);
    step(700);
    chk("wd expiry", 1'b1, supplies_off);
    rchk("wd cause", A_POFF_A, 8'h04);
    wreg(8'h1A, 8'h02);
    wreg(A_POFF_A, 8'hFF);
    wake;
    wreg(8'hFF, 8'hC6);
    step(5200);
    chk("second wd", 1'b1, supplies_off);
    $display("test watchdog done");
  endtask
  initial begin
    do_reset;
    t_reset;
    t_rw;
    do_reset;
    t_status;
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_causes;
    t_wake;
    t_wdog;
    wrap_up;
  end
endmodule

// ---- design/pmu_state_control_registers.sv ----
`timescale 1ns/1ps
// Functional notes
// - power-off mode bit: 0 sequenced supply shutdown, 1 all supplies at once.
// - wake pin polarity: high level, low level, rising edge, falling edge.
// - sleep request powers off at once, or after 8 ms with delay bit set.
// - in state two the power-ok reset output follows its level select bit.
// - over-temperature protection gated by enable (reset 1); 2-bit trip threshold.
// - bus over-current interrupt threshold, 2 bits, 0.5 A to 2.0 A, reset 01.
// - bus switch over-current threshold, 3 bits; code 111 disables that protection.
// - bus under-voltage threshold, 2 bits, 3.90 V to 4.70 V, reset 10.
// - bus switch over-voltage threshold bit: 0 is 6 V, 1 is 6.5 V.
// - bus switch wake threshold bit: 0 is 4.0 V, 1 is 4.3 V, reset 1.
// - battery low threshold, 2 bits, 3.2 V to 3.5 V, reset 01.
// - converter good bits read 1 only when output good, 0 if disabled.
// - regulator good bits read 1 only when that regulator output is good.
// - sticky power-off cause flags record every kind of shutdown event.
// - host writing 1 clears a cause flag; writing 0 leaves it.
// - legacy watchdog runs only when enabled; timeout 0.5, 2, 8, 16 s.
// - watchdog clear bit is write-only; writing 1 restarts the count.
// - select bit picks legacy or second watchdog, each with own enable, timeout.
// - masked regulator fault turns that regulator off only; unmasked goes to state three.
// - converter frequency select, 3 bits, 0.6 to 2 MHz, reset 010.
// - bus switch shutdown speed: 11 fast, 00 slow, reset 11.
// - bus 5 kilohm pull-down enable bit, reset 0.
// - serial slave at write address 0x60; register updates after full byte.
module pmu_state_control_registers #(
  parameter int unsigned TICK_CYCLES = pmu_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wake_pin,
  input wire logic alarm_event,
  input wire logic key_long_event,
  input wire logic key_short_event,
  input wire logic bus_insert_event,
  input wire logic path_oc_event,
  input wire logic bus_switch_oc_event,
  input wire logic pwrok_fault_event,
  input wire logic overtemp_event,
  input wire logic low_power_event,
  input wire logic key_reset_event,
  input wire logic reset_in_low_event,
  input wire logic path_ov_event,
  input wire logic [6:0] reg_fault,
  input wire logic [5:0] reg_oc_flag,
  input wire logic [2:0] conv_pg_in,
  input wire logic [6:0] reg_pg_in,
  output logic supplies_off,
  output logic simultaneous_off_select,
  output logic reset_out,
  output logic [6:0] regulator_force_off,
  output logic overtemp_protect_enable,
  output logic [1:0] overtemp_threshold,
  output logic [1:0] bus_overcurrent_irq_threshold,
  output logic [2:0] bus_switch_overcurrent_threshold,
  output logic [1:0] bus_undervoltage_threshold,
  output logic bus_switch_overvoltage_threshold,
  output logic bus_switch_wake_threshold,
  output logic [1:0] battery_low_threshold,
  output logic [2:0] switching_frequency_select,
  output logic [1:0] bus_switch_shutdown_speed,
  output logic bus_pulldown_enable
);
  import pmu_pkg::*;

  typedef enum logic [1:0] {state_one, off_wait, state_two, state_three} pst_e;
  typedef enum logic [2:0] {i_idle, i_addr, i_reg, i_wdata, i_ack, i_rdata, i_mack} i2c_e;

  typedef struct packed {
    pst_e st;
    logic [N_RW-1:0][7:0] rw;
    logic [7:0] poff_a;
    logic [1:0] poff_b;
    logic [7:0] pon_a;
    logic [7:0] pon_b;
    logic [7:0] ocf;
    logic [7:0] cpg;
    logic [7:0] rpg;
    logic [6:0] force_off;
    logic supplies_off;
    logic reset_out;
    logic pin_q;
    logic kick;
    logic [16:0] tick_cnt;
    logic tick;
    logic [3:0] dly_cnt;
    i2c_e ist;
    i2c_e after;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rd;
    logic mack;
    logic sda_oe;
    logic sda_out;
  } state_s;

  state_s q;
  state_s d;

  logic wr_en;
  logic [7:0] wr_ptr;
  logic [7:0] wr_dat;
  logic [7:0] poff_set_a;
  logic [1:0] poff_set_b;
  logic fault;
  logic live;
  logic pin_hit;
  logic [4:0] wake_src;
  logic ot_trip;
  logic [6:0] soft_flt;
  logic wd_old_exp;
  logic wd_new_exp;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < N_RW; i++) begin
      if (a == RW_ADDR[i]) begin
        v = q.rw[i];
      end
    end
    case (a)
      A_OCFLAG: v = q.ocf;
      A_CONV_PG: v = q.cpg;
      A_REG_PG: v = q.rpg;
      A_PON_A: v = q.pon_a;
      A_POFF_A: v = q.poff_a;
      A_POFF_B: v = {6'h00, q.poff_b};
      A_PON_B: v = q.pon_b;
      default: ;
    endcase
    return v;
  endfunction

  always_comb begin
    d = q;
    wr_en = 1'b0;
    wr_ptr = q.ptr;
    wr_dat = q.shift;
    d.scl_q = scl_in;
    d.sda_q = sda_in;
    rise = scl_in & ~q.scl_q;
    fall = ~scl_in & q.scl_q;
    start = scl_in & q.scl_q & q.sda_q & ~sda_in;
    stop = scl_in & q.scl_q & ~q.sda_q & sda_in;

    // serial slave; open drain, so only the enable toggles
    if (start) begin
      d.ist = i_addr;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.ist = i_idle;
      d.sda_oe = 1'b0;
    end else begin
      case (q.ist)
        i_addr, i_reg, i_wdata: begin
          if (rise && q.bitcnt < 4'h8) begin
            d.shift = {q.shift[6:0], sda_in};
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (fall && q.bitcnt == 4'h8) begin
            d.bitcnt = 4'h0;
            d.sda_oe = 1'b1;
            d.ist = i_ack;
            if (q.ist == i_addr) begin
              d.rd = q.shift[0];
              d.after = q.shift[0] ? i_rdata : i_reg;
              if (q.shift[7:1] != SLAVE_ADDR) begin
                d.sda_oe = 1'b0;
                d.ist = i_idle;
              end
            end else if (q.ist == i_reg) begin
              d.ptr = q.shift;
              d.after = i_wdata;
            end else begin
              wr_en = 1'b1;
              d.ptr = q.ptr + 8'h01;
              d.after = i_wdata;
            end
          end
        end
        i_ack: begin
          if (fall) begin
            d.sda_oe = 1'b0;
            d.ist = q.after;
            if (q.after == i_rdata) begin
              d.shift = rd_byte(q.ptr);
              d.sda_oe = ~d.shift[7];
              d.bitcnt = 4'h1;
            end
          end
        end
        i_rdata: begin
          if (fall) begin
            if (q.bitcnt < 4'h8) begin
              d.shift = {q.shift[6:0], 1'b0};
              d.sda_oe = ~q.shift[6];
              d.bitcnt = q.bitcnt + 4'h1;
            end else begin
              d.sda_oe = 1'b0;
              d.ist = i_mack;
            end
          end
        end
        i_mack: begin
          if (rise) begin
            d.mack = ~sda_in;
          end
          if (fall) begin
            if (q.mack) begin
              d.ptr = q.ptr + 8'h01;
              d.shift = rd_byte(q.ptr + 8'h01);
              d.sda_oe = ~d.shift[7];
              d.bitcnt = 4'h1;
              d.ist = i_rdata;
            end else begin
              d.ist = i_idle;
            end
          end
        end
        i_idle: ;
        default: d.ist = i_idle;
      endcase
    end

    // register bank; fixed bits keep their reset value
    for (int i = 0; i < N_RW; i++) begin
      if (wr_en && wr_ptr == RW_ADDR[i]) begin
        d.rw[i] = (q.rw[i] & ~RW_WMASK[i]) | (wr_dat & RW_WMASK[i]);
      end
    end
    d.kick = wr_en && wr_ptr == RW_ADDR[IDX_WDOG] && wr_dat[B_WD_CLR];

    // millisecond tick
    d.tick = 1'b0;
    d.tick_cnt = q.tick_cnt + 17'h00001;
    if (q.tick_cnt == 17'(TICK_CYCLES - 1)) begin
      d.tick = 1'b1;
      d.tick_cnt = 17'h00000;
    end

    // status sampling; a disabled converter never reads good
    d.ocf = {reg_oc_flag, 2'b00};
    d.cpg = {4'h0, conv_pg_in & q.rw[IDX_DCC][F_DC_EN+:3], 1'b0};
    d.rpg = {reg_pg_in, 1'b0};

    // wake sources
    d.pin_q = wake_pin;
    case (q.rw[IDX_CTL1][F_POL+:2])
      POL_HIGH: pin_hit = wake_pin;
      POL_LOW: pin_hit = ~wake_pin;
      POL_RISE: pin_hit = wake_pin & ~q.pin_q;
      POL_FALL: pin_hit = ~wake_pin & q.pin_q;
      default: pin_hit = 1'b0;
    endcase
    wake_src = {alarm_event & q.rw[IDX_CTL0][B_WK_ALM], pin_hit & q.rw[IDX_CTL0][B_WK_PIN],
                key_long_event & q.rw[IDX_CTL0][B_WK_KL], key_short_event & q.rw[IDX_CTL0][B_WK_KS],
                bus_insert_event & q.rw[IDX_CTL0][B_WK_BUS]};

    // shutdown causes only count while the supplies are up
    live = q.st == state_one || q.st == off_wait;
    ot_trip = overtemp_event & q.rw[IDX_TEMP][B_EN_TEMP];
    soft_flt = live ? reg_fault & q.rw[IDX_MASK][7:1] : 7'h00;
    poff_set_a = 8'h00;
    poff_set_b = 2'b00;
    if (live) begin
      poff_set_a[7] = path_oc_event | (bus_switch_oc_event & (q.rw[IDX_BUSB][F_SOCH+:3] != SOCH_OFF));
      poff_set_a[6] = |(reg_fault & ~q.rw[IDX_MASK][7:1]);
      poff_set_a[5] = pwrok_fault_event;
      poff_set_a[4] = ot_trip;
      poff_set_a[3] = low_power_event;
      poff_set_a[2] = wd_old_exp | wd_new_exp;
      poff_set_a[1] = key_reset_event;
      poff_set_b = {reset_in_low_event, path_ov_event};
    end
    fault = |poff_set_a[7:1] | |poff_set_b;
    d.force_off = q.force_off | soft_flt;

    // power state sequencing
    case (q.st)
      state_one: begin
        if (fault) begin
          d.st = state_three;
        end else if (q.rw[IDX_CTL0][B_SLEEP]) begin
          d.st = q.rw[IDX_SET][B_DELAY] ? off_wait : state_two;
          d.dly_cnt = 4'h0;
        end
      end
      off_wait: begin
        if (fault) begin
          d.st = state_three;
        end else if (q.tick) begin
          d.dly_cnt = q.dly_cnt + 4'h1;
          if (q.dly_cnt == 4'(OFF_DELAY_MS - 1)) begin
            d.st = state_two;
          end
        end
      end
      state_two, state_three: begin
        if (|wake_src) begin
          d.st = state_one;
          d.force_off = 7'h00;
          d.pon_a = {3'h0, wake_src[3], 1'b0, wake_src[1], wake_src[2], wake_src[0]};
          d.pon_b = {6'h00, wake_src[4], 1'b0};
        end
      end
      default: d.st = state_one;
    endcase
    poff_set_a[0] = d.st == state_two && q.st != state_two;
    if (live && d.st != state_one && d.st != off_wait) begin
      d.rw[IDX_CTL0][B_SLEEP] = 1'b0;
    end

    // cause flags: an event in the clearing cycle still lands
    d.poff_a = (q.poff_a & ~((wr_en && wr_ptr == A_POFF_A) ? wr_dat : 8'h00)) | poff_set_a;
    d.poff_b = (q.poff_b & ~((wr_en && wr_ptr == A_POFF_B) ? wr_dat[1:0] : 2'b00)) | poff_set_b;

    d.supplies_off = d.st == state_two || d.st == state_three;
    case (d.st)
      state_two: d.reset_out = d.rw[IDX_SET][B_POR_S2];
      state_three: d.reset_out = 1'b0;
      default: d.reset_out = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.rw <= RW_RST;
      q.reset_out <= 1'b1;
      q.scl_q <= 1'b1;
      q.sda_q <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // only the selected watchdog may run
  pmu_watchdog u_wd_old (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(q.tick),
    .enable(q.rw[IDX_WDOG][B_WD_EN] & ~q.rw[IDX_WD1][B_WD_SEL]),
    .kick(q.kick),
    .timeout(q.rw[IDX_WDOG][F_WD_TIM+:2]),
    .expire(wd_old_exp)
  );

  pmu_watchdog u_wd_new (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(q.tick),
    .enable(q.rw[IDX_WD1][B_WDN_EN] & q.rw[IDX_WD1][B_WD_SEL]),
    .kick(q.kick),
    .timeout(q.rw[IDX_WD1][F_WDN_TIM+:2]),
    .expire(wd_new_exp)
  );

  assign sda_out = q.sda_out;
  assign sda_oe = q.sda_oe;
  assign supplies_off = q.supplies_off;
  assign simultaneous_off_select = q.rw[IDX_CTL0][B_SIMUL];
  assign reset_out = q.reset_out;
  assign regulator_force_off = q.force_off;
  assign overtemp_protect_enable = q.rw[IDX_TEMP][B_EN_TEMP];
  assign overtemp_threshold = q.rw[IDX_TEMP][F_VTH+:2];
  assign bus_overcurrent_irq_threshold = q.rw[IDX_BUSA][F_BUSOC+:2];
  assign bus_switch_overcurrent_threshold = q.rw[IDX_BUSB][F_SOCH+:3];
  assign bus_undervoltage_threshold = q.rw[IDX_BUSB][F_UV+:2];
  assign bus_switch_overvoltage_threshold = q.rw[IDX_BUSA][B_OVSET];
  assign bus_switch_wake_threshold = q.rw[IDX_BUSB][B_OKSET];
  assign battery_low_threshold = q.rw[IDX_CTL2][F_BATLB+:2];
  assign switching_frequency_select = q.rw[IDX_DCC][F_FRQ+:3];
  assign bus_switch_shutdown_speed = q.rw[IDX_BUSA][F_SID+:2];
  assign bus_pulldown_enable = q.rw[IDX_BUSB][B_PD5K];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_pin_rise;
    !wake_pin ##1 wake_pin;
  endsequence

  a_w1c_clear: assert property (wr_en && wr_ptr == A_POFF_A && poff_set_a == 8'h00 |=> (q.poff_a & $past(wr_dat)) == 8'h00)
    else $error("cause flag not cleared");
  a_w0_keep: assert property (wr_en && wr_ptr == A_POFF_A |=> (q.poff_a & $past(q.poff_a & ~wr_dat)) == $past(q.poff_a & ~wr_dat))
    else $error("cause flag lost on write of zero");
  a_cause_sticky: assert property (poff_set_a != 8'h00 |=> (q.poff_a & $past(poff_set_a)) == $past(poff_set_a))
    else $error("cause event not recorded");
  a_sleep_now: assert property (q.st == state_one && q.rw[IDX_CTL0][B_SLEEP] && !q.rw[IDX_SET][B_DELAY] && !fault
    |=> q.st == state_two && supplies_off) else $error("immediate sleep missed");
  a_sleep_delay: assert property (q.st == off_wait && q.tick && q.dly_cnt == 4'(OFF_DELAY_MS - 1) && !fault
    |=> q.st == state_two) else $error("delayed sleep missed");
  a_wait_hold: assert property (q.st == off_wait && !q.tick && !fault |=> q.st == off_wait && !supplies_off)
    else $error("left delay early");
  a_s2_level: assert property (q.st == state_two |-> reset_out == q.rw[IDX_SET][B_POR_S2])
    else $error("reset level wrong in state two");
  a_mask_stay: assert property (q.st == state_one && (reg_fault & q.rw[IDX_MASK][7:1]) != 7'h00 && !fault
    |=> q.st == state_one && (regulator_force_off & $past(reg_fault)) != 7'h00) else $error("masked fault");
  a_unmask_off: assert property (q.st == state_one && (reg_fault & ~q.rw[IDX_MASK][7:1]) != 7'h00
    |=> q.st == state_three && reset_out == 1'b0) else $error("unmasked fault kept on");
  a_wake_edge: assert property ((s_pin_rise ##0 (q.st == state_two && q.rw[IDX_CTL1][F_POL+:2] == POL_RISE
    && q.rw[IDX_CTL0][B_WK_PIN])) |=> q.st == state_one && q.pon_a[4]) else $error("rising wake missed");
  a_otp_gate: assert property (overtemp_event && !q.rw[IDX_TEMP][B_EN_TEMP] |=> !$rose(q.poff_a[4]))
    else $error("disabled overtemp recorded");
  a_reg_update: assert property (q.rw[IDX_BUSB] != $past(q.rw[IDX_BUSB]) |-> $past(wr_en) && $past(wr_ptr) == 8'h0A)
    else $error("register changed without full byte");
  a_pg_gate: assert property (1'b1 |=> q.cpg[3:1] == ($past(conv_pg_in) & $past(q.rw[IDX_DCC][2:0])))
    else $error("power good ignores enable");

endmodule

// ---- design/pmu_watchdog.sv ----
`timescale 1ns/1ps
module pmu_watchdog (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic kick,
  input wire logic [1:0] timeout,
  output logic expire
);
  import pmu_pkg::*;

  typedef struct packed {
    logic [14:0] cnt;
    logic expire;
  } wd_s;

  wd_s q;
  wd_s d;
  logic [14:0] limit;

  always_comb begin
    case (timeout)
      2'h0: limit = WD_MS_0;
      2'h1: limit = WD_MS_1;
      2'h2: limit = WD_MS_2;
      default: limit = WD_MS_3;
    endcase
  end

  always_comb begin
    d = q;
    d.expire = 1'b0;
    if (!enable || kick) begin
      d.cnt = 15'h0000;
    end else if (tick) begin
      if (q.cnt >= limit - 15'h0001) begin
        d.expire = 1'b1;
        d.cnt = 15'h0000;
      end else begin
        d.cnt = q.cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.expire;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_kick_restart: assert property (kick |=> q.cnt == 15'h0000 && !q.expire) else $error("kick did not restart");
  a_expire_limit: assert property (q.expire |-> $past(tick) && $past(enable) && $past(q.cnt) == $past(limit) - 15'h0001)
    else $error("watchdog expired off limit");
  a_idle_off: assert property (!enable |=> !q.expire) else $error("disabled watchdog expired");

endmodule

// ---- inc/pmu_pkg.sv ----
package pmu_pkg;

  // timing: one millisecond tick drives every slow count
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int OFF_DELAY_MS = 8;
  localparam logic [14:0] WD_MS_0 = 15'h01F4;
  localparam logic [14:0] WD_MS_1 = 15'h07D0;
  localparam logic [14:0] WD_MS_2 = 15'h1F40;
  localparam logic [14:0] WD_MS_3 = 15'h3E80;

  // serial bus slave address, write byte 0x60
  localparam logic [6:0] SLAVE_ADDR = 7'h30;

  // read-write bank: index, offset, reset value, writable bits
  localparam int N_RW = 16;
  localparam int IDX_CTL0 = 0;
  localparam int IDX_CTL1 = 1;
  localparam int IDX_CTL2 = 2;
  localparam int IDX_SET = 4;
  localparam int IDX_TEMP = 6;
  localparam int IDX_BUSA = 7;
  localparam int IDX_BUSB = 8;
  localparam int IDX_WDOG = 11;
  localparam int IDX_MASK = 12;
  localparam int IDX_DCC = 13;
  localparam int IDX_WD1 = 15;
  localparam logic [N_RW-1:0][7:0] RW_ADDR = {8'hFF, 8'h97, 8'h20, 8'h1B, 8'h1A, 8'h19, 8'h18, 8'h0A,
                                              8'h09, 8'h08, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00};
  localparam logic [N_RW-1:0][7:0] RW_RST = {8'h26, 8'h55, 8'h10, 8'h00, 8'h02, 8'h00, 8'h00, 8'hA4,
                                             8'hCB, 8'h06, 8'h79, 8'h04, 8'h00, 8'hA9, 8'h01, 8'h18};
  localparam logic [N_RW-1:0][7:0] RW_WMASK = {8'hFF, 8'hFF, 8'h3F, 8'hFE, 8'h0B, 8'h0E, 8'hFE, 8'hFF,
                                               8'hFF, 8'hF7, 8'h03, 8'hFE, 8'hFF, 8'h2F, 8'h79, 8'hFF};

  // read-only and clear-on-one offsets
  localparam logic [7:0] A_OCFLAG = 8'h0C;
  localparam logic [7:0] A_CONV_PG = 8'h0D;
  localparam logic [7:0] A_REG_PG = 8'h0E;
  localparam logic [7:0] A_PON_A = 8'h10;
  localparam logic [7:0] A_POFF_A = 8'h11;
  localparam logic [7:0] A_POFF_B = 8'h12;
  localparam logic [7:0] A_PON_B = 8'h1C;

  // field positions
  localparam int B_SLEEP = 0;
  localparam int B_SIMUL = 1;
  localparam int B_WK_BUS = 3;
  localparam int B_WK_KS = 4;
  localparam int B_WK_KL = 5;
  localparam int B_WK_PIN = 6;
  localparam int B_WK_ALM = 7;
  localparam int F_POL = 4;
  localparam int F_BATLB = 0;
  localparam int B_DELAY = 7;
  localparam int B_POR_S2 = 6;
  localparam int F_VTH = 0;
  localparam int B_EN_TEMP = 2;
  localparam int F_SID = 0;
  localparam int B_OVSET = 2;
  localparam int F_BUSOC = 3;
  localparam int B_PD5K = 0;
  localparam int B_OKSET = 2;
  localparam int F_SOCH = 3;
  localparam int F_UV = 6;
  localparam int F_WD_TIM = 0;
  localparam int B_WD_CLR = 2;
  localparam int B_WD_EN = 3;
  localparam int F_WDN_TIM = 4;
  localparam int B_WDN_EN = 6;
  localparam int B_WD_SEL = 7;
  localparam int F_DC_EN = 0;
  localparam int F_FRQ = 3;

  // encodings
  localparam logic [1:0] POL_HIGH = 2'h0;
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_RISE = 2'h2;
  localparam logic [1:0] POL_FALL = 2'h3;
  localparam logic [2:0] SOCH_OFF = 3'h7;

endpackage
